// File: wdk_keepalive_host.sv
// Purpose: keep-alive supervisor that refreshes the watchdog clear ports
// Assumes: health packets return as one-cycle pulses on the same clock
// Notes:   registers on a plain port, read data one cycle after the strobe
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "wdk_defines.svh"
module wdk_keepalive_host
  import wdk_pkg::*;
#(
  parameter int unsigned RUN_CYCLES = 32'(`WDK_RUN_CYCLES)
) (
  input  wire logic        clock_in,
  input  wire logic        rstn_in,
  wdk_io_if.host           io,
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic        packet_return_in,
  output logic [15:0]      reg_rdata_out,
  output logic             irq_out,
  output logic             packet_issue_out
);
  logic                  run_tick;

  // control and timer state
  logic                  override_reg;
  logic                  override_next;
  logic                  enable_reg;
  logic                  enable_next;
  wdk_word_t             reload_reg;
  wdk_word_t             reload_next;
  wdk_word_t             countdown_reg;
  wdk_word_t             countdown_next;
  wdk_word_t             loop_count_reg;
  wdk_word_t             loop_count_next;
  wdk_word_t             loop_seen_reg;
  wdk_word_t             loop_seen_next;
  logic                  issue_next;

  // port refresh sequencer
  wdk_host_state_t       state_reg;
  wdk_host_state_t       state_next;
  wdk_port_t             io_addr_reg;
  wdk_port_t             io_addr_next;
  logic                  io_wr_reg;
  logic                  io_wr_next;

  // event and register port state
  logic [`WDK_EV_W-1:0]  status_reg;
  logic [`WDK_EV_W-1:0]  status_next;
  logic [`WDK_EV_W-1:0]  mask_reg;
  logic [`WDK_EV_W-1:0]  mask_next;
  logic [`WDK_EV_W-1:0]  ev_set;
  logic [`WDK_EV_W-1:0]  ev_clr;
  wdk_word_t             rdata_next;
  logic                  irq_next;
  logic                  wr_ctrl;
  logic                  wr_status;
  logic                  wr_mask;
  logic                  wr_reload;
  logic                  loop_adv;
  logic                  refresh_ok;
  logic                  expire_now;

  // run interval must stay below the hardware timeout
  wdk_period_tick #(
    .PERIOD (RUN_CYCLES)
  ) u_run (
    .clock_in (clock_in),
    .rstn_in  (rstn_in),
    .tick_out (run_tick)
  );

  // keep-alive timers
  always_comb
  begin
    wr_ctrl   = reg_wr_in && (reg_addr_in == `WDK_REG_CTRL);
    wr_reload = reg_wr_in && (reg_addr_in == `WDK_REG_RELOAD);
    override_next = wr_ctrl ? reg_wdata_in[`WDK_CTRL_OVERRIDE] : override_reg;
    enable_next   = wr_ctrl ? reg_wdata_in[`WDK_CTRL_ENABLE] : enable_reg;
    reload_next   = wr_reload ? reg_wdata_in : reload_reg;

    // one time update per run sends a health packet round the loop
    issue_next      = run_tick && enable_reg;
    loop_count_next = packet_return_in ? loop_count_reg + 16'h0001 : loop_count_reg;
    loop_adv        = (loop_count_reg != loop_seen_reg);
    loop_seen_next  = loop_count_reg;

    // a stalled loop lets the count-down run out
    expire_now     = 1'b0;
    countdown_next = countdown_reg;
    if (loop_adv || io.proc_reset)
      countdown_next = reload_reg;
    else if (run_tick && enable_reg && (countdown_reg != 16'h0000))
    begin
      countdown_next = countdown_reg - 16'h0001;
      expire_now     = (countdown_reg == 16'h0001);
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      override_reg     <= 1'b0;
      enable_reg       <= 1'b1;
      reload_reg       <= `WDK_RELOAD_RST;
      countdown_reg    <= `WDK_RELOAD_RST;
      loop_count_reg   <= 16'h0000;
      loop_seen_reg    <= 16'h0000;
      packet_issue_out <= 1'b0;
    end
    else
    begin
      override_reg     <= override_next;
      enable_reg       <= enable_next;
      reload_reg       <= reload_next;
      countdown_reg    <= countdown_next;
      loop_count_reg   <= loop_count_next;
      loop_seen_reg    <= loop_seen_next;
      packet_issue_out <= issue_next;
    end
  end

  // port refresh: both clear ports, one access each, back to back
  always_comb
  begin
    // override refreshes every run; otherwise only while count-down runs
    refresh_ok   = override_reg || (enable_reg && (countdown_reg != 16'h0000));
    state_next   = state_reg;
    io_addr_next = io_addr_reg;
    io_wr_next   = 1'b0;
    case (state_reg)
      wdk_st_idle:
      begin
        if (run_tick && refresh_ok)
        begin
          state_next   = wdk_st_wr_a;
          io_addr_next = `WDK_CLR_PORT_A;
          io_wr_next   = 1'b1;
        end
      end
      wdk_st_wr_a:
      begin
        state_next   = wdk_st_wr_b;
        io_addr_next = `WDK_CLR_PORT_B;
        io_wr_next   = 1'b1;
      end
      wdk_st_wr_b:
      begin
        state_next   = wdk_st_idle;
        io_addr_next = 8'h00;
      end
      default:
      begin
        state_next   = wdk_st_idle;
        io_addr_next = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_reg   <= wdk_st_idle;
      io_addr_reg <= 8'h00;
      io_wr_reg   <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      io_addr_reg <= io_addr_next;
      io_wr_reg   <= io_wr_next;
    end
  end

  assign io.io_addr = io_addr_reg;
  assign io.io_wr   = io_wr_reg;

  // events, mask, interrupt and read port
  always_comb
  begin
    wr_status = reg_wr_in && (reg_addr_in == `WDK_REG_STATUS);
    wr_mask   = reg_wr_in && (reg_addr_in == `WDK_REG_MASK);
    ev_set                      = '0;
    ev_set[`WDK_EV_EXPIRED]     = expire_now;
    ev_set[`WDK_EV_LOOP]        = loop_adv;
    ev_set[`WDK_EV_PROC_RESET]  = io.proc_reset;
    ev_set[`WDK_EV_REFRESH]     = (state_reg == wdk_st_wr_b);
    ev_clr      = wr_status ? reg_wdata_in[`WDK_EV_W-1:0] : '0;
    // a new event in the clearing cycle survives the write
    status_next = (status_reg & ~ev_clr) | ev_set;
    mask_next   = wr_mask ? reg_wdata_in[`WDK_EV_W-1:0] : mask_reg;
    irq_next    = |(status_next & mask_next);
    rdata_next  = 16'h0000;
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        `WDK_REG_CTRL:      rdata_next = {14'h0000, enable_reg, override_reg};
        `WDK_REG_STATUS:    rdata_next = {12'h000, status_reg};
        `WDK_REG_MASK:      rdata_next = {12'h000, mask_reg};
        `WDK_REG_LOOP:      rdata_next = loop_count_reg;
        `WDK_REG_RELOAD:    rdata_next = reload_reg;
        `WDK_REG_COUNTDOWN: rdata_next = countdown_reg;
        default:            rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      status_reg    <= '0;
      mask_reg      <= '0;
      irq_out       <= 1'b0;
      reg_rdata_out <= 16'h0000;
    end
    else
    begin
      status_reg    <= status_next;
      mask_reg      <= mask_next;
      irq_out       <= irq_next;
      reg_rdata_out <= rdata_next;
    end
  end
endmodule

// File: wdk_defines.svh
// Purpose: constants for the watchdog keep-alive pair (counter end and supervisor end)
// Assumes: 20 MHz clock_in on both ends
// Notes:   the counter end sits behind two clear ports on the processor i/o bus
//
// How it works
// - ten-bit counter advances on each slow tick
// - counter top bit rising resets the processor
// - roughly 67 seconds from clear to reset
// - counter clears only after both ports accessed
// - a second instance is cleared only by the bench's own port accesses
// - supervisor runs faster than the hardware timeout
// - override flag forces clear accesses every run
// - zero count-down stops the clear accesses unless the override flag is set
// - loop count advance reloads the count-down
// - returning health packet bumps loop count
`ifndef WDK_DEFINES_SVH
`define WDK_DEFINES_SVH

`define WDK_CLK_HZ          64'd20000000
// slow timebase, in millihertz so the fraction survives
`define WDK_TICK_MILLIHZ    64'd7629
`define WDK_TICK_CYCLES     ((`WDK_CLK_HZ * 64'd1000) / `WDK_TICK_MILLIHZ)
// nominal timeout in seconds: 512 ticks of the slow timebase
`define WDK_TIMEOUT_S       67
`define WDK_CNT_W           10
`define WDK_CNT_TOP         (`WDK_CNT_W - 1)
// supervisor run interval, well under the hardware timeout
`define WDK_RUN_MS          64'd1000
`define WDK_RUN_CYCLES      ((`WDK_CLK_HZ / 64'd1000) * `WDK_RUN_MS)

// clear ports on the processor i/o bus
`define WDK_CLR_PORT_A      8'h40
`define WDK_CLR_PORT_B      8'h41

// supervisor register map
`define WDK_REG_CTRL        4'h0
`define WDK_REG_STATUS      4'h1
`define WDK_REG_MASK        4'h2
`define WDK_REG_LOOP        4'h3
`define WDK_REG_RELOAD      4'h4
`define WDK_REG_COUNTDOWN   4'h5
`define WDK_CTRL_OVERRIDE   0
`define WDK_CTRL_ENABLE     1
`define WDK_CTRL_RST        16'h0002
`define WDK_RELOAD_RST      16'h000a
`define WDK_EV_W            4
`define WDK_EV_EXPIRED      0
`define WDK_EV_LOOP         1
`define WDK_EV_PROC_RESET   2
`define WDK_EV_REFRESH      3

`endif

// File: wdk_pkg.sv
// Purpose: shared types for the watchdog keep-alive pair
// Assumes: constants come from wdk_defines.svh
// Notes:   types only
package wdk_pkg;

  typedef enum logic [1:0] {
    wdk_st_idle,
    wdk_st_wr_a,
    wdk_st_wr_b
  } wdk_host_state_t;

  typedef logic [7:0]  wdk_port_t;
  typedef logic [15:0] wdk_word_t;

endpackage

// File: wdk_io_if.sv
// Purpose: processor i/o port bus between supervisor and watchdog counter
// Assumes: both ends on clock_in
// Notes:   io_wr is a one-cycle port access strobe
`timescale 1ns/1ps
interface wdk_io_if;
  logic [7:0] io_addr;
  logic       io_wr;
  logic       proc_reset;

  modport device (
    input  io_addr,
    input  io_wr,
    output proc_reset
  );

  modport host (
    output io_addr,
    output io_wr,
    input  proc_reset
  );
endinterface

// File: wdk_period_tick.sv
// Purpose: one-cycle tick every PERIOD clocks
// Assumes: PERIOD of at least 1
// Notes:   free running from reset
`timescale 1ns/1ps
module wdk_period_tick #(
  parameter int unsigned PERIOD = 32'd2621575
) (
  input  wire logic clock_in,
  input  wire logic rstn_in,
  output logic      tick_out
);
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic        tick_next;

  always_comb
  begin
    tick_next = (cnt_reg == PERIOD - 32'd1);
    cnt_next  = tick_next ? 32'h0000_0000 : cnt_reg + 32'h0000_0001;
  end

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cnt_reg  <= 32'h0000_0000;
      tick_out <= 1'b0;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      tick_out <= tick_next;
    end
  end
endmodule

// File: wdk_watchdog_dev.sv
// Purpose: processor watchdog counter with a pair of clear ports
// Assumes: port accesses arrive on the same clock
// Notes:   proc_reset is a one-cycle pulse on the counter top bit rising
`timescale 1ns/1ps
`include "wdk_defines.svh"
module wdk_watchdog_dev
  import wdk_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 32'(`WDK_TICK_CYCLES)
) (
  input  wire logic                  clock_in,
  input  wire logic                  rstn_in,
  wdk_io_if.device                   io,
  output logic [`WDK_CNT_W-1:0]      count_out,
  output logic                       trip_out
);
  logic                  slow_tick;
  logic [`WDK_CNT_W-1:0] count_reg;
  logic [`WDK_CNT_W-1:0] count_next;
  logic                  seen_a_reg;
  logic                  seen_a_next;
  logic                  seen_b_reg;
  logic                  seen_b_next;
  logic                  trip_next;
  logic                  acc_a;
  logic                  acc_b;
  logic                  clear_now;

  wdk_period_tick #(
    .PERIOD (TICK_CYCLES)
  ) u_tick (
    .clock_in (clock_in),
    .rstn_in  (rstn_in),
    .tick_out (slow_tick)
  );

  always_comb
  begin
    acc_a     = io.io_wr && (io.io_addr == `WDK_CLR_PORT_A);
    acc_b     = io.io_wr && (io.io_addr == `WDK_CLR_PORT_B);
    // either order counts; the pair completes on the second access
    clear_now = (acc_a && seen_b_reg) || (acc_b && seen_a_reg);
    seen_a_next = clear_now ? 1'b0 : (seen_a_reg || acc_a);
    seen_b_next = clear_now ? 1'b0 : (seen_b_reg || acc_b);
    // top bit about to go 0 to 1: 512 ticks after a clear
    trip_next = slow_tick && !clear_now
                && (count_reg == {1'b0, {(`WDK_CNT_W-1){1'b1}}});
    count_next = count_reg;
    if (clear_now || trip_next)
      count_next = '0;
    else if (slow_tick)
      count_next = count_reg + `WDK_CNT_W'(1);
  end

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      count_reg     <= '0;
      seen_a_reg    <= 1'b0;
      seen_b_reg    <= 1'b0;
      trip_out      <= 1'b0;
      io.proc_reset <= 1'b0;
    end
    else
    begin
      count_reg     <= count_next;
      seen_a_reg    <= seen_a_next;
      seen_b_reg    <= seen_b_next;
      trip_out      <= trip_next;
      io.proc_reset <= trip_next;
    end
  end

  assign count_out = count_reg;
endmodule

// File: wdk_assertions.sv
// Purpose: link and counter checks for the watchdog keep-alive pair
// Assumes: one clock domain, reset active low
// Notes:   watches the first link only; the bench drives the second
`timescale 1ns/1ps
`include "wdk_defines.svh"
module wdk_assertions (
  input wire logic       clock_in,
  input wire logic       rstn_in,
  input wire logic [7:0] io_addr,
  input wire logic       io_wr,
  input wire logic       proc_reset,
  input wire logic [9:0] count_out,
  input wire logic       trip_out,
  input wire logic       packet_issue_out
);
  default clocking dc @(posedge clock_in);
  endclocking
  default disable iff (!rstn_in);
  wire wr_a = io_wr && io_addr == `WDK_CLR_PORT_A;
  wire wr_b = io_wr && io_addr == `WDK_CLR_PORT_B;

  a_count_step: assert property (count_out != $past(count_out) |->
    count_out == $past(count_out) + 10'h1 || count_out == 10'h0) else $error("count jumped");
  a_trip_top: assert property (trip_out |->
    count_out == 10'h0 && $past(count_out) == 10'h1ff) else $error("trip off top bit");
  a_trip_link: assert property (trip_out == proc_reset) else $error("trip and reset differ");
  a_pair_clear: assert property (wr_a ##1 wr_b |=> count_out == 10'h0)
    else $error("pair did not clear");
  a_clear_cause: assert property ($fell(|count_out) && $past(count_out) != 10'h1ff |->
    $past(io_wr)) else $error("clear without access");
  a_host_pair: assert property (wr_a |=> wr_b ##1 !io_wr) else $error("pair order");
  a_host_addr: assert property (io_wr |-> wr_a || wr_b) else $error("stray port");
  a_issue_pulse: assert property (packet_issue_out |=> !packet_issue_out [*8])
    else $error("runs too close");
  a_reset_quiet: assert property (!$past(rstn_in) |->
    count_out == 10'h0 && !io_wr && !trip_out) else $error("not quiet after reset");

  c_trip: cover property (trip_out);
  c_pair: cover property (wr_a ##1 wr_b);
  c_issue: cover property (packet_issue_out);
endmodule

// File: testbench.sv
// Purpose: self-checking bench for the watchdog keep-alive pair
// Assumes: short tick and run periods set below
// Notes:   second counter end is driven by the bench to break the pairing
`timescale 1ns/1ps
`include "wdk_defines.svh"
module testbench
  import wdk_pkg::*;
;
  localparam int unsigned TICK = 4;
  localparam int unsigned RUN  = 20;
  logic       clock_in  = 1'b0;
  logic       rstn_in   = 1'b0;
  logic [3:0] reg_addr  = 4'h0;
  wdk_word_t  reg_wdata = 16'h0;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic       pkt_ret   = 1'b0;
  logic       loop_on   = 1'b0;
  logic       rd_d      = 1'b0;
  wdk_word_t  rdata;
  logic       irq, issue, trip;
  logic [9:0] count, count2;
  int         err_count = 0;
  int         checks = 0;
  int         cyc = 0;
  int         clr_cyc = 0;
  int         returns = 0;
  int         trips = 0;
  int         dly = 0;
  wdk_word_t  exp_q[$];
  wdk_io_if   io();
  wdk_io_if   io2();

  always #25 clock_in = ~clock_in;

  wdk_watchdog_dev #(.TICK_CYCLES(TICK)) u_wdk_watchdog_dev (.clock_in(clock_in),
    .rstn_in(rstn_in), .io(io.device), .count_out(count), .trip_out(trip));
  wdk_watchdog_dev #(.TICK_CYCLES(TICK)) u_wdk_watchdog_dev_b (.clock_in(clock_in),
    .rstn_in(rstn_in), .io(io2.device), .count_out(count2), .trip_out());
  wdk_keepalive_host #(.RUN_CYCLES(RUN)) u_wdk_keepalive_host (.clock_in(clock_in),
    .rstn_in(rstn_in), .io(io.host), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .packet_return_in(pkt_ret),
    .reg_rdata_out(rdata), .irq_out(irq), .packet_issue_out(issue));
  wdk_assertions u_wdk_assertions (.clock_in(clock_in), .rstn_in(rstn_in),
    .io_addr(io.io_addr), .io_wr(io.io_wr), .proc_reset(io.proc_reset),
    .count_out(count), .trip_out(trip), .packet_issue_out(issue));

  task automatic close_out();
    if (err_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input wdk_word_t v, input wdk_word_t e);
    checks++;
    if (v !== e)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, v, e);
    end
  endtask

  task automatic wr(input logic [3:0] a, input wdk_word_t d);
    @(posedge clock_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock_in);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input wdk_word_t e);
    @(posedge clock_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock_in);
    reg_rd <= 1'b0;
  endtask

  // port access on the second link; address inverted once released
  task automatic pw(input logic [7:0] a);
    @(posedge clock_in);
    io2.io_addr <= a;
    io2.io_wr <= 1'b1;
    @(posedge clock_in);
    io2.io_wr <= 1'b0;
    io2.io_addr <= ~a;
  endtask

  task automatic do_reset();
    rstn_in <= 1'b0;
    repeat (8) @(posedge clock_in);
    rstn_in <= 1'b1;
  endtask

  task automatic reg_sweep();
    logic [3:0] a[7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hf};
    wdk_word_t  v[7] = '{16'h0002, 16'h0, 16'h0, 16'h0, 16'h000a, 16'h000a, 16'h0};
    for (int i = 0; i < 7; i++) rd(a[i], v[i]);
  endtask

  task automatic wait_trip(input int n);
    repeat (n)
    begin
      @(negedge clock_in);
      if (trip === 1'b1) return;
    end
    err_count++;
    $display("Error at %0t: no trip, got %h expected %h", $time, trip, 1'b1);
  endtask

  always @(posedge clock_in) rd_d <= reg_rd;
  always @(negedge clock_in)
  begin
    if (rd_d) chk(rdata, exp_q.pop_front());
    if (trip === 1'b1) trips++;
  end

  // far processors: each packet issued while loop_on is set comes back a few cycles later
  always @(posedge clock_in)
  begin
    pkt_ret <= dly == 1;
    returns <= returns + int'(dly == 1);
    if (issue && loop_on) dly <= 1 + $urandom % 4;
    else if (dly > 0) dly <= dly - 1;
  end

  always @(posedge clock_in)
  begin
    cyc <= cyc + 1;
    if (io.io_wr && io.io_addr == `WDK_CLR_PORT_B) clr_cyc <= cyc;
    if (cyc > 20000)
    begin
      err_count++;
      $display("Error at %0t: cycle limit, got %h expected %h", $time, cyc, 20000);
      close_out();
    end
  end

  initial
  begin
    io2.io_addr = 8'h0;
    io2.io_wr = 1'b0;
    void'($urandom(90869));
    do_reset();
    reg_sweep();
    // short reload: only a live loop keeps refreshing past the timeout
    wr(4'h4, 16'h0002);
    wr(4'h2, 16'h0002);
    rd(4'h4, 16'h0002);
    loop_on <= 1'b1;
    repeat (2500) @(posedge clock_in);
    chk(16'(trips), 16'h0);
    chk(16'(irq), 16'h1);
    loop_on <= 1'b0;
    repeat (10) @(posedge clock_in);
    rd(4'h3, 16'(returns));
    wr(4'h1, 16'h000f);
    @(negedge clock_in);
    chk(16'(irq), 16'h0);
    wait_trip(3000);
    chk(16'((cyc - clr_cyc) inside {[512 * TICK - 7 : 512 * TICK + 5]}), 16'h1);
    rd(4'h1, 16'h000d);
    chk(16'(irq), 16'h0);
    // override alone, with the run enable off, must still hold off the trip
    wr(4'h0, 16'h0001);
    rd(4'h0, 16'h0001);
    repeat (3000) @(posedge clock_in);
    chk(16'(trips), 16'h1);
    // reverse-order pair first, so the lone access later meets a known small count
    pw(`WDK_CLR_PORT_B);
    pw(`WDK_CLR_PORT_A);
    @(negedge clock_in);
    chk(16'(count2), 16'h0);
    repeat (20) @(posedge clock_in);
    pw(`WDK_CLR_PORT_A);
    pw(8'h42 + 8'($urandom % 190));
    @(negedge clock_in);
    chk(16'(count2 != 10'h0), 16'h1);
    pw(`WDK_CLR_PORT_B);
    @(negedge clock_in);
    chk(16'(count2), 16'h0);
    @(posedge clock_in);
    do_reset();
    @(negedge clock_in);
    chk(16'(count), 16'h0);
    reg_sweep();
    close_out();
  end
endmodule
